// file: hdl/linkage_defines.vh
/*
  Register offsets, field positions, reset values and selector codes
  of the state linkage histogram block.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef LINKAGE_DEFINES_VH
`define LINKAGE_DEFINES_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_EVENT_EN    8'h08
`define OFS_TOT_SAMPLES 8'h0C
`define OFS_TOT_LINKS   8'h10
`define OFS_LINK_BASE   8'h20
`define OFS_EVENT_BASE  8'h40
`define OFS_COUNT_BASE  8'h80
`define OFS_PCT_BASE    8'hA0

// ************************************************************
// control fields and reset values
// ************************************************************
`define CTRL_RUN_BIT    0
`define CTRL_CLEAR_BIT  1
`define CTRL_RATE_LSB   4
`define CTRL_RATE_MSB   7
`define LINK_EN_BIT     8
`define CTRL_RESET      32'h0000_0000
`define LINK_RESET      9'h000
`define EVENT_RESET     32'h0000_0000
`define LFSR_SEED       16'hACE1

// ************************************************************
// selector codes for link type positions
// ************************************************************
`define SEL_ANY         4'h8
`define SEL_OTHER       4'h9

// ************************************************************
// percentage scale
// ************************************************************
`define PCT_SCALE       40'h00_0000_0064

`endif

// file: hdl/sat_counter.v
/*
  Saturating 32-bit event counter with synchronous clear.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module sat_counter (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // control
  input  wire        clear_in,
  input  wire        inc_in,
  // value
  output reg  [31:0] count_out
);

  // count, stick at all ones, clear on new measurement
  always @(posedge clk_sys_in) begin
    if (rst_in || clear_in) begin
      count_out <= 32'h0000_0000;
    end else if (inc_in && (count_out != 32'hFFFF_FFFF)) begin
      count_out <= count_out + 32'h0000_0001;
    end
  end

endmodule // sat_counter

`default_nettype wire

// file: hdl/pct_divider.v
/*
  Sequential restoring divider, one quotient bit per clock.
  Assumes start is a one-cycle pulse and inputs hold while busy.
*/
`timescale 1ns/1ps
`default_nettype none

module pct_divider (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // request
  input  wire        start_in,
  input  wire [39:0] num_in,
  input  wire [31:0] den_in,
  // answer
  output reg         done_out,
  output reg  [39:0] quo_out
);

  reg [32:0] rem_reg;
  reg [39:0] num_reg;
  reg [5:0]  step_reg;
  reg        busy_reg;
  wire [32:0] trial_w = {rem_reg[31:0], num_reg[39]};

  // shift, compare, subtract
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rem_reg  <= 33'h0_0000_0000;
      num_reg  <= 40'h00_0000_0000;
      step_reg <= 6'h00;
      busy_reg <= 1'b0;
      done_out <= 1'b0;
      quo_out  <= 40'h00_0000_0000;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        rem_reg  <= 33'h0_0000_0000;
        num_reg  <= num_in;
        step_reg <= 6'h28;
        busy_reg <= 1'b1;
        quo_out  <= 40'h00_0000_0000;
      end else if (busy_reg) begin
        num_reg <= {num_reg[38:0], 1'b0};
        if (trial_w >= {1'b0, den_in}) begin
          rem_reg <= trial_w - {1'b0, den_in};
          quo_out <= {quo_out[38:0], 1'b1};
        end else begin
          rem_reg <= trial_w;
          quo_out <= {quo_out[38:0], 1'b0};
        end
        step_reg <= step_reg - 6'h01;
        if (step_reg == 6'h01) begin
          busy_reg <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end

endmodule // pct_divider

`default_nettype wire

// file: hdl/state_linkage_histogram.v
/*
  State linkage histogram: sorts sampled target states into events,
  pairs consecutive samples into link types and keeps statistics,
  all reached over an Avalon-MM slave with waitrequest.
  Assumes the state bus is synchronous to clk_sys_in and that the
  bus master holds each request until waitrequest is seen low.
*/
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "linkage_defines.vh"

module state_linkage_histogram (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // target state bus
  input  wire [15:0] state_addr_in,
  input  wire [7:0]  state_data_in,
  input  wire [7:0]  state_stat_in,
  input  wire        state_valid_in,
  // avalon-mm slave
  input  wire [7:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  // status
  output reg         running_out
);

  // ************************************************************
  // functions
  // ************************************************************

  // masked compare of one state against one event; mask zero ignores
  function ev_match;
    input [15:0] a;
    input [7:0]  d;
    input [7:0]  s;
    input [31:0] wa;
    input [31:0] wd;
    begin
      ev_match = (((a ^ wa[15:0]) & wa[31:16]) == 16'h0000) &&
                 (((d ^ wd[7:0]) & wd[15:8]) == 8'h00) &&
                 (((s ^ wd[23:16]) & wd[31:24]) == 8'h00);
    end
  endfunction

  // selector against the event hits of one sample
  function sel_hit;
    input [3:0] sel;
    input [7:0] hits;
    begin
      if (sel == `SEL_ANY) begin
        sel_hit = 1'b1;
      end else if (sel[3] == 1'b0) begin
        sel_hit = hits[sel[2:0]];
      end else begin
        sel_hit = 1'b0;
      end
    end
  endfunction

  // byte-enable merge of a write
  function [31:0] merge_be;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0]  be;
    integer k;
    begin
      merge_be = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge_be[k*8 +: 8] = wdat[k*8 +: 8];
        end
      end
    end
  endfunction

  // ************************************************************
  // configuration registers
  // ************************************************************
  reg  [31:0] ctrl_reg;
  reg  [7:0]  ev_en_reg;
  reg  [8:0]  link_reg [0:7];
  reg  [31:0] ev_a_reg [0:7];
  reg  [31:0] ev_d_reg [0:7];
  reg         clear_reg;
  reg  [15:0] lfsr_reg;

  // ************************************************************
  // sampling pipeline
  // ************************************************************
  reg  [7:0]  cur_hit_reg;
  reg  [7:0]  prev_hit_reg;
  reg         cap_last_reg;
  reg         pair_ok_reg;
  reg         samp_stb_reg;
  reg  [7:0]  hit_next;
  reg  [15:0] rate_mask_next;
  wire        gate_w;
  integer     e;

  // event recognition of the incoming state
  // eight enabled events
  always @* begin
    hit_next = 8'h00;
    for (e = 0; e < 8; e = e + 1) begin
      hit_next[e] = ev_en_reg[e] &
                    ev_match(state_addr_in, state_data_in, state_stat_in,
                             ev_a_reg[e], ev_d_reg[e]);
    end
  end

  // random gate mask from the rate field
  always @* begin
    rate_mask_next = (16'h0001 << ctrl_reg[`CTRL_RATE_MSB:`CTRL_RATE_LSB]) - 16'h0001;
  end
  assign gate_w = ((lfsr_reg & rate_mask_next) == 16'h0000);

  // continuous capture; a skipped state breaks the pair
  // continuous random sampling
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      lfsr_reg     <= `LFSR_SEED;
      cur_hit_reg  <= 8'h00;
      prev_hit_reg <= 8'h00;
      cap_last_reg <= 1'b0;
      pair_ok_reg  <= 1'b0;
      samp_stb_reg <= 1'b0;
    end else begin
      lfsr_reg     <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^
                       lfsr_reg[12] ^ lfsr_reg[10]};
      samp_stb_reg <= 1'b0;
      if (clear_reg || !ctrl_reg[`CTRL_RUN_BIT]) begin
        cap_last_reg <= 1'b0;
        pair_ok_reg  <= 1'b0;
      end else if (state_valid_in) begin
        if (gate_w) begin
          samp_stb_reg <= 1'b1;
          cur_hit_reg  <= hit_next;
          prev_hit_reg <= cur_hit_reg;
          pair_ok_reg  <= cap_last_reg;
          cap_last_reg <= 1'b1;
        end else begin
          cap_last_reg <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // link type classification
  // ************************************************************
  reg  [7:0] base_ok;
  reg  [7:0] type_hit;
  reg        blocked;
  reg        lo;
  reg        to;
  integer    i;
  integer    j;

  always @* begin
    base_ok  = 8'h00;
    type_hit = 8'h00;
    blocked  = 1'b0;
    lo       = 1'b0;
    to       = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      base_ok[i] = link_reg[i][`LINK_EN_BIT] &&
                   (link_reg[i][3:0] != `SEL_OTHER) &&
                   (link_reg[i][7:4] != `SEL_OTHER) &&
                   sel_hit(link_reg[i][3:0], prev_hit_reg) &&
                   sel_hit(link_reg[i][7:4], cur_hit_reg);
    end
    for (i = 0; i < 8; i = i + 1) begin
      lo = (link_reg[i][3:0] == `SEL_OTHER);
      to = (link_reg[i][7:4] == `SEL_OTHER);
      blocked = 1'b0;
      for (j = 0; j < 8; j = j + 1) begin
        // both positions other: any plain hit blocks the pair
        if ((j != i) && base_ok[j] &&
            ((lo && to) ||
             ((!lo || (link_reg[j][7:4] == link_reg[i][7:4])) &&
              (!to || (link_reg[j][3:0] == link_reg[i][3:0]))))) begin
          blocked = 1'b1;
        end
      end
      type_hit[i] = base_ok[i] |
                    (link_reg[i][`LINK_EN_BIT] && (lo || to) && !blocked &&
                     (lo || sel_hit(link_reg[i][3:0], prev_hit_reg)) &&
                     (to || sel_hit(link_reg[i][7:4], cur_hit_reg)));
    end
    type_hit = type_hit & {8{pair_ok_reg}};
  end

  // ************************************************************
  // statistics counters
  // ************************************************************
  wire [31:0] samples_w;
  wire [31:0] links_w;
  wire [31:0] type_cnt_w [0:7];

  sat_counter u_samples (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .clear_in   (clear_reg),
    .inc_in     (samp_stb_reg),
    .count_out  (samples_w)
  );

  sat_counter u_links (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .clear_in   (clear_reg),
    .inc_in     (samp_stb_reg & (|type_hit)),
    .count_out  (links_w)
  );

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_type
      sat_counter u_type (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .clear_in   (clear_reg),
        .inc_in     (samp_stb_reg & type_hit[g]),
        .count_out  (type_cnt_w[g])
      );
    end
  endgenerate

  // ************************************************************
  // percentage divider
  // ************************************************************
  reg         div_start_reg;
  reg  [39:0] div_num_reg;
  wire        div_done_w;
  wire [39:0] div_quo_w;

  pct_divider u_div (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .start_in   (div_start_reg),
    .num_in     (div_num_reg),
    .den_in     (links_w),
    .done_out   (div_done_w),
    .quo_out    (div_quo_w)
  );

  // ************************************************************
  // avalon slave
  // ************************************************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_DIV  = 2'b01;
  localparam [1:0] ST_ACK  = 2'b10;

  reg  [1:0]  state_reg;
  reg  [31:0] rd_next;
  localparam [7:0] PCT_BASE = `OFS_PCT_BASE;
  wire [2:0]  idx_w = avs_address_in[4:2];
  wire        is_pct_w = (avs_address_in[7:5] == PCT_BASE[7:5]);
  // lane merge of a link type write, cut to the 9 stored bits below
  wire [31:0] link_merge_w = merge_be({23'h00_0000, link_reg[idx_w]},
                                      avs_writedata_in, avs_byteenable_in);
  integer     r;

  // read mux of the plain registers
  always @* begin
    rd_next = 32'h0000_0000;
    case (avs_address_in[7:5])
      3'h0: begin
        case (avs_address_in)
          `OFS_CTRL:        rd_next = ctrl_reg & ~(32'h0000_0001 << `CTRL_CLEAR_BIT);
          `OFS_STATUS:      rd_next = {31'h0000_0000, ctrl_reg[`CTRL_RUN_BIT]};
          `OFS_EVENT_EN:    rd_next = {24'h00_0000, ev_en_reg};
          `OFS_TOT_SAMPLES: rd_next = samples_w;
          `OFS_TOT_LINKS:   rd_next = links_w;
          default:          rd_next = 32'h0000_0000;
        endcase
      end
      3'h1:    rd_next = {23'h00_0000, link_reg[idx_w]};
      3'h2:    rd_next = avs_address_in[2] ? ev_d_reg[avs_address_in[4:3]] :
                                             ev_a_reg[avs_address_in[4:3]];
      3'h3:    rd_next = avs_address_in[2] ? ev_d_reg[{1'b1, avs_address_in[4:3]}] :
                                             ev_a_reg[{1'b1, avs_address_in[4:3]}];
      3'h4:    rd_next = type_cnt_w[idx_w];
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // handshake: one wait cycle, or until the divider is done
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg           <= ST_IDLE;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
      div_start_reg       <= 1'b0;
      div_num_reg         <= 40'h00_0000_0000;
    end else begin
      div_start_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (avs_read_in && is_pct_w) begin
            div_num_reg   <= {8'h00, type_cnt_w[idx_w]} * `PCT_SCALE;
            div_start_reg <= 1'b1;
            state_reg     <= ST_DIV;
          end else if (avs_read_in || avs_write_in) begin
            avs_readdata_out    <= avs_read_in ? rd_next : 32'h0000_0000;
            avs_waitrequest_out <= 1'b0;
            state_reg           <= ST_ACK;
          end
        end
        ST_DIV: begin
          if (div_done_w) begin
            avs_readdata_out    <= (links_w == 32'h0000_0000) ? 32'h0000_0000 :
                                   div_quo_w[31:0];
            avs_waitrequest_out <= 1'b0;
            state_reg           <= ST_ACK;
          end
        end
        ST_ACK: begin
          avs_waitrequest_out <= 1'b1;
          state_reg           <= ST_IDLE;
        end
        default: begin
          avs_waitrequest_out <= 1'b1;
          state_reg           <= ST_IDLE;
        end
      endcase
    end
  end

  // register writes land on the edge that completes the transfer
  // run start clears counters
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_reg    <= `CTRL_RESET;
      ev_en_reg   <= 8'h00;
      clear_reg   <= 1'b0;
      running_out <= 1'b0;
      for (r = 0; r < 8; r = r + 1) begin
        link_reg[r] <= `LINK_RESET;
        ev_a_reg[r] <= `EVENT_RESET;
        ev_d_reg[r] <= `EVENT_RESET;
      end
    end else begin
      clear_reg   <= 1'b0;
      running_out <= ctrl_reg[`CTRL_RUN_BIT];
      if ((state_reg == ST_ACK) && avs_write_in) begin
        case (avs_address_in[7:5])
          3'h0: begin
            if (avs_address_in == `OFS_CTRL) begin
              ctrl_reg  <= merge_be(ctrl_reg, avs_writedata_in, avs_byteenable_in) &
                           ~(32'h0000_0001 << `CTRL_CLEAR_BIT);
              clear_reg <= avs_byteenable_in[0] &&
                           (avs_writedata_in[`CTRL_CLEAR_BIT] ||
                            (avs_writedata_in[`CTRL_RUN_BIT] && !ctrl_reg[`CTRL_RUN_BIT]));
            end else if ((avs_address_in == `OFS_EVENT_EN) && avs_byteenable_in[0]) begin
              ev_en_reg <= avs_writedata_in[7:0];
            end
          end
          3'h1: begin
            link_reg[idx_w] <= link_merge_w[8:0];
          end
          3'h2, 3'h3: begin
            if (avs_address_in[2]) begin
              ev_d_reg[{avs_address_in[5], avs_address_in[4:3]}] <=
                merge_be(ev_d_reg[{avs_address_in[5], avs_address_in[4:3]}],
                         avs_writedata_in, avs_byteenable_in);
            end else begin
              ev_a_reg[{avs_address_in[5], avs_address_in[4:3]}] <=
                merge_be(ev_a_reg[{avs_address_in[5], avs_address_in[4:3]}],
                         avs_writedata_in, avs_byteenable_in);
            end
          end
          default: begin
            ctrl_reg <= ctrl_reg;
          end
        endcase
      end
    end
  end

endmodule // state_linkage_histogram

`default_nettype wire

// file: tb/state_linkage_histogram_assertions.sv
/* checker: bus answer timing, readout bounds and run status of the block.
   assumes it is bound onto the block's own ports. */
`timescale 1ns/1ps
`default_nettype none
module state_linkage_histogram_assertions (
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  // avalon-mm slave
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // status
  input wire logic        running_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // read answer and percentage window
  wire ack_rd = avs_read_in && !avs_waitrequest_out;
  wire pct_a  = avs_address_in[7:5] == 3'h5;
  wire ctl_a  = avs_address_in[7:2] == 6'h00;

  rst_idle_a: assert property (disable iff (1'b0) rst_in |=>
    avs_waitrequest_out && avs_readdata_out == 32'h0 && !running_out)
    else $error("outputs not idle after reset");
  wait_once_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  ack_bound_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |-> ##[0:43] !avs_waitrequest_out) else $error("request not answered");
  plain_ack_a: assert property (($rose(avs_read_in) && !pct_a) || $rose(avs_write_in)
    |=> !avs_waitrequest_out) else $error("plain access not answered next cycle");
  pct_wait_a: assert property ($rose(avs_read_in) && pct_a |->
    avs_waitrequest_out [*8] ##36 !avs_waitrequest_out) else $error("share read latency wrong");
  pct_bound_a: assert property (ack_rd && pct_a |-> avs_readdata_out <= 32'h64)
    else $error("share above one hundred");
  unmap_zero_a: assert property (ack_rd && avs_address_in[7:2] == 6'h05
    |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  data_hold_a: assert property (avs_waitrequest_out && $past(avs_waitrequest_out) &&
    !$past(rst_in) |-> $stable(avs_readdata_out)) else $error("read data moved while idle");
  stat_run_a: assert property (ack_rd && avs_address_in[7:2] == 6'h01
    |-> avs_readdata_out[0] == running_out) else $error("status run differs from running");
  run_follow_a: assert property (avs_write_in && !avs_waitrequest_out && ctl_a &&
    avs_byteenable_in[0] |-> ##2 running_out == $past(avs_writedata_in[0], 2))
    else $error("running does not follow run write");

  cover property (ack_rd && pct_a);
  cover property (avs_write_in && !avs_waitrequest_out);
  cover property ($rose(running_out));
endmodule // state_linkage_histogram_assertions

bind state_linkage_histogram state_linkage_histogram_assertions u_chk (.clk_sys_in, .rst_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
  .avs_readdata_out, .avs_waitrequest_out, .running_out);
`default_nettype wire

// file: tb/state_bus_model.sv
/* target state bus model: one state per clock on request.
   assumes the bench calls send and idle from one process. */
`timescale 1ns/1ps
`default_nettype none
module state_bus_model (
  // clock
  input  wire logic        clk_sys_in,
  // target state bus
  output logic [15:0] state_addr_out,
  output logic [7:0]  state_data_out,
  output logic [7:0]  state_stat_out,
  output logic        state_valid_out
);
  initial begin
    state_addr_out = 16'h0000;
    state_data_out = 8'h00;
    state_stat_out = 8'h00;
    state_valid_out = 1'b0;
  end
  // one state, data taken from the upper address byte
  task send(input logic [15:0] a);
    @(posedge clk_sys_in);
    state_addr_out <= a;
    state_data_out <= a[15:8];
    state_stat_out <= 8'h5A;
    state_valid_out <= 1'b1;
  endtask
  // released bus shows inverted, moving values
  task idle;
    @(posedge clk_sys_in);
    state_valid_out <= 1'b0;
    state_addr_out <= ~state_addr_out;
    state_data_out <= ~state_data_out;
    state_stat_out <= ~state_stat_out;
  endtask
endmodule // state_bus_model
`default_nettype wire

// file: tb/state_linkage_histogram_tb_top.sv
/* bench: configures events and link types, plays states, checks counters.
   assumes the bus model and bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module state_linkage_histogram_tb_top;
  logic        clk_sys_in = 1'b0;
  logic        rst_in;
  logic [7:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  wire logic [31:0] avs_readdata_out;
  wire logic        avs_waitrequest_out;
  wire logic        running_out;
  wire logic [15:0] s_addr;
  wire logic [7:0]  s_data;
  wire logic [7:0]  s_stat;
  wire logic        s_valid;
  integer      miscompares = 0;
  integer      check_count = 0;
  logic [31:0] rd;
  // link types: e0>e1, other>e1, e0>any, any>any, off event e2>any, disabled, other>other
  logic [8:0]  lt [7] = '{9'h110, 9'h119, 9'h180, 9'h188, 9'h182, 9'h010, 9'h199};
  logic [31:0] cnt [7] = '{32'h1, 32'h1, 32'h1, 32'h3, 32'h0, 32'h0, 32'h0};

  always #20 clk_sys_in = ~clk_sys_in;

  state_bus_model u_bus (.clk_sys_in(clk_sys_in), .state_addr_out(s_addr),
    .state_data_out(s_data), .state_stat_out(s_stat), .state_valid_out(s_valid));
  state_linkage_histogram u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .state_addr_in(s_addr), .state_data_in(s_data), .state_stat_in(s_stat),
    .state_valid_in(s_valid), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .running_out(running_out));

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task av(input logic we, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
    integer n;
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_byteenable_in <= be;
    if (we) avs_write_in <= 1'b1;
    else avs_read_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    if (n >= 100) chk("waitrequest", avs_waitrequest_out, 32'h0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    av(1'b0, a, 32'h0, 4'hF);
    chk(name, rd, exp);
  endtask
  task finish_test;
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task t_reset;
    rdchk("ctrl", 8'h00, 32'h0);
    rdchk("samples", 8'h0C, 32'h0);
    rdchk("link0", 8'h20, 32'h0);
    rdchk("event0", 8'h40, 32'h0);
    rdchk("unmapped", 8'h14, 32'h0);
  endtask
  // e0 on address and status, e1 on data only, e2 defined but off
  task t_config;
    av(1'b1, 8'h40, 32'hFFFF_1000, 4'hF);
    av(1'b1, 8'h44, 32'hFF5A_0000, 4'hF);
    av(1'b1, 8'h4C, 32'h0000_FF20, 4'hF);
    av(1'b1, 8'h50, 32'hFFFF_3000, 4'hF);
    av(1'b1, 8'h08, 32'h0000_0003, 4'h0);
    rdchk("enable lanes", 8'h08, 32'h0);
    av(1'b1, 8'h08, 32'h0000_0003, 4'hF);
    rdchk("enable", 8'h08, 32'h3);
    for (int i = 0; i < 7; i++) av(1'b1, 8'h20 | {i[3:0], 2'b00}, {23'h0, lt[i]}, 4'hF);
    rdchk("link5", 8'h34, 32'h010);
  endtask
  // states a b c b: pairs ab, bc, cb
  task t_sort;
    av(1'b1, 8'h00, 32'h1, 4'hF);
    rdchk("status", 8'h04, 32'h1);
    chk("running", running_out, 32'h1);
    u_bus.send(16'h1000);
    u_bus.send(16'h2000);
    u_bus.send(16'h3000);
    u_bus.send(16'h2000);
    u_bus.idle();
    repeat (4) @(posedge clk_sys_in);
    rdchk("samples", 8'h0C, 32'h4);
    rdchk("links", 8'h10, 32'h3);
    for (int i = 0; i < 7; i++) begin
      rdchk("count", 8'h80 | {i[3:0], 2'b00}, cnt[i]);
      rdchk("share", 8'hA0 | {i[3:0], 2'b00}, cnt[i] * 32'h64 / 32'h3);
    end
  endtask
  task t_stop;
    av(1'b1, 8'h00, 32'h0, 4'hF);
    u_bus.send(16'h1000);
    u_bus.send(16'h2000);
    u_bus.idle();
    repeat (4) @(posedge clk_sys_in);
    rdchk("stopped", 8'h0C, 32'h4);
    rdchk("status", 8'h04, 32'h0);
    chk("running", running_out, 32'h0);
  endtask
  task t_clear;
    av(1'b1, 8'h00, 32'h3, 4'hF);
    rdchk("samples", 8'h0C, 32'h0);
    rdchk("links", 8'h10, 32'h0);
    rdchk("count3", 8'h8C, 32'h0);
    rdchk("share3", 8'hAC, 32'h0);
  endtask

  initial begin
    rst_in = 1'b1;
    avs_address_in = 8'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'hF;
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_reset;
    t_config;
    t_sort;
    t_stop;
    t_clear;
    finish_test;
  end
  // watchdog
  initial begin
    #(40 * 5000);
    miscompares++;
    finish_test;
  end
endmodule // state_linkage_histogram_tb_top
`default_nettype wire
